// [verilog/tld_setpoint_loader.sv]
// Set point loader for two 9-bit delta-sigma outputs with temperature tables and a 256-byte auxiliary memory.
// Assumes the serial slave hands over one byte access per request and the converter pulses once per result.
//
// Summary of operation
// - First table indexed by temperature, 4 degree steps.
// - Load first value on conversion or software write, hold otherwise.
// - Manual mode stops first output table loading.
// - Alignment bit places first entry high or low.
// - Second table indexed by temperature, 4 degree steps.
// - Load second value on conversion or software write, hold otherwise.
// - Manual mode stops second output table loading.
// - Alignment bit places second entry high or low.
// - Table writes need high password or low plus grant.
// - Table reads need high, or low plus either grant.
// - Reserved A4h-A7h unused; second table denies them.
// - Auxiliary 256 bytes answer at slave A0h.
// - Auxiliary access needs high, or low plus grant.
// - Tables and auxiliary memory clear to zero.
`timescale 1ns/1ps
`default_nettype none

module tld_setpoint_loader (
  input  wire logic                              i_clock,
  input  wire logic                              i_rstn,
  input  wire tld_pkg::tld_access_t              i_access,
  input  wire tld_pkg::tld_security_t            i_security,
  input  wire logic signed [tld_pkg::TEMP_W-1:0] i_temperature,
  input  wire logic                              i_conversion_done,
  output logic [7:0]                             o_rdata,
  output logic                                   o_rvalid,
  output logic                                   o_denied,
  output logic [tld_pkg::INDEX_W-1:0]            o_temperature_table_index,
  output logic [tld_pkg::CODE_W-1:0]             o_first_output_value,
  output logic [tld_pkg::CODE_W-1:0]             o_second_output_value
);
  import tld_pkg::*;

  logic [7:0] lookup_table_first  [LUT_ENTRIES];
  logic [7:0] lookup_table_second [LUT_ENTRIES];
  logic [7:0] aux_user_memory     [AUX_BYTES];
  logic [7:0] mode;

  // Index computation.
  logic signed [TEMP_SUM_W-1:0] temp_shifted;
  logic signed [TEMP_SUM_W-1:0] temp_steps;
  logic        [INDEX_W-1:0]    index_calc;
  assign temp_shifted = TEMP_SUM_W'(i_temperature) + TEMP_OFFSET;
  assign temp_steps   = temp_shifted >>> TEMP_STEP_SHIFT;
  // Readings below -40 use the first entry and above +100 the last one.
  assign index_calc   = (temp_steps < 0) ? '0 :
                        (temp_steps > TEMP_SUM_W'(INDEX_LAST)) ? INDEX_LAST :
                        INDEX_W'(temp_steps);

  // Entries aligned into the 9-bit codes.
  logic [7:0]        first_entry;
  logic [7:0]        second_entry;
  logic [CODE_W-1:0] first_aligned;
  logic [CODE_W-1:0] second_aligned;
  logic              first_manual;
  logic              second_manual;
  assign first_manual   = mode[MODE_FIRST_MANUAL];
  assign second_manual  = mode[MODE_SECOND_MANUAL];
  assign first_entry    = lookup_table_first[index_calc];
  assign second_entry   = lookup_table_second[index_calc];
  assign first_aligned  = mode[MODE_FIRST_ALIGN] ? {first_entry, 1'b0} : {1'b0, first_entry};
  assign second_aligned = mode[MODE_SECOND_ALIGN] ? {second_entry, 1'b0} : {1'b0, second_entry};

  // Access decode.
  logic              is_main;
  logic              is_aux;
  logic              is_ctrl;
  logic              is_first;
  logic              is_second;
  logic              in_lut;
  logic              in_rsvd;
  logic [INDEX_W-1:0] lut_slot;
  logic              tbl_wr_ok;
  logic              tbl_rd_ok;
  logic              aux_ok;
  assign is_main   = i_access.slave == MAIN_SLAVE_ADDR;
  assign is_aux    = i_access.slave == AUX_SLAVE_ADDR;
  assign is_ctrl   = is_main && (i_access.table_sel == TABLE_CONTROL);
  assign is_first  = is_main && (i_access.table_sel == TABLE_FIRST);
  assign is_second = is_main && (i_access.table_sel == TABLE_SECOND);
  assign in_lut    = (i_access.offset >= LUT_BASE) && (i_access.offset <= LUT_END);
  assign in_rsvd   = (i_access.offset >= RSVD_FIRST) && (i_access.offset <= RSVD_LAST);
  assign lut_slot  = INDEX_W'(i_access.offset - LUT_BASE);
  assign tbl_wr_ok = i_security.high_level_password ||
                     (i_security.low_level_password && i_security.output_tables_write_grant);
  assign tbl_rd_ok = i_security.high_level_password ||
                     (i_security.low_level_password &&
                      (i_security.output_tables_write_grant || i_security.output_tables_read_grant));
  assign aux_ok    = i_security.high_level_password ||
                     (i_security.low_level_password &&
                      (i_security.aux_memory_grant || i_security.aux_memory_user_grant));

  logic wr_first_lut;
  logic wr_second_lut;
  logic wr_aux;
  logic wr_ctrl;
  assign wr_first_lut  = i_access.write && is_first && in_lut && tbl_wr_ok;
  assign wr_second_lut = i_access.write && is_second && in_lut && tbl_wr_ok;
  assign wr_aux        = i_access.write && is_aux && aux_ok;
  assign wr_ctrl       = i_access.write && is_ctrl;

  // Write acceptance: reserved bytes of the first table are accepted but store nothing.
  logic write_ok;
  assign write_ok = wr_first_lut || wr_second_lut || wr_aux ||
                    (i_access.write && is_first && in_rsvd && tbl_wr_ok) ||
                    (wr_ctrl && ((i_access.offset == CTRL_MODE_ADDR) ||
                                 ((i_access.offset >= FIRST_VALUE_HI) && (i_access.offset <= SECOND_VALUE_LO))));

  // Read selection; the control index byte is read only.
  logic [7:0] ctrl_rdata;
  logic       ctrl_hit;
  logic [7:0] read_data;
  logic       read_ok;
  assign ctrl_hit   = (i_access.offset == CTRL_MODE_ADDR) || (i_access.offset == CTRL_INDEX_ADDR) ||
                      ((i_access.offset >= FIRST_VALUE_HI) && (i_access.offset <= SECOND_VALUE_LO));
  assign ctrl_rdata = (i_access.offset == CTRL_MODE_ADDR)  ? mode :
                      (i_access.offset == CTRL_INDEX_ADDR) ? 8'(o_temperature_table_index) :
                      (i_access.offset == FIRST_VALUE_HI)  ? 8'(o_first_output_value[CODE_W-1]) :
                      (i_access.offset == FIRST_VALUE_LO)  ? o_first_output_value[7:0] :
                      (i_access.offset == SECOND_VALUE_HI) ? 8'(o_second_output_value[CODE_W-1]) :
                      o_second_output_value[7:0];
  assign read_ok    = (is_aux && aux_ok) ||
                      (is_first && (in_lut || in_rsvd) && tbl_rd_ok) ||
                      (is_second && in_lut && tbl_rd_ok) ||
                      (is_ctrl && ctrl_hit);
  assign read_data  = !read_ok ? DENIED_BYTE :
                      is_aux ? aux_user_memory[i_access.offset] :
                      is_ctrl ? ctrl_rdata :
                      (is_first && in_lut) ? lookup_table_first[lut_slot] :
                      (is_second && in_lut) ? lookup_table_second[lut_slot] :
                      FACTORY_BYTE;

  // Software value writes, merged per byte into the held codes.
  logic              wr_first_hi;
  logic              wr_first_lo;
  logic              wr_second_hi;
  logic              wr_second_lo;
  logic [CODE_W-1:0] next_first_value;
  logic [CODE_W-1:0] next_second_value;
  assign wr_first_hi  = wr_ctrl && (i_access.offset == FIRST_VALUE_HI);
  assign wr_first_lo  = wr_ctrl && (i_access.offset == FIRST_VALUE_LO);
  assign wr_second_hi = wr_ctrl && (i_access.offset == SECOND_VALUE_HI);
  assign wr_second_lo = wr_ctrl && (i_access.offset == SECOND_VALUE_LO);

  // A table load wins over a software write in the same cycle, since auto mode owns the value.
  assign next_first_value =
    (i_conversion_done && !first_manual) ? first_aligned :
    wr_first_hi ? {i_access.wdata[0], o_first_output_value[7:0]} :
    wr_first_lo ? {o_first_output_value[CODE_W-1], i_access.wdata} :
    o_first_output_value;
  assign next_second_value =
    (i_conversion_done && !second_manual) ? second_aligned :
    wr_second_hi ? {i_access.wdata[0], o_second_output_value[7:0]} :
    wr_second_lo ? {o_second_output_value[CODE_W-1], i_access.wdata} :
    o_second_output_value;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_first_output_value      <= '0;
      o_second_output_value     <= '0;
      o_temperature_table_index <= '0;
      mode                      <= '0;
    end else begin
      o_first_output_value  <= next_first_value;
      o_second_output_value <= next_second_value;
      if (i_conversion_done) begin
        o_temperature_table_index <= index_calc;
      end
      if (wr_ctrl && (i_access.offset == CTRL_MODE_ADDR)) begin
        mode <= i_access.wdata & MODE_MASK;
      end
    end
  end

  // Reset stands in for the factory fill of the nonvolatile arrays.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      for (int i = 0; i < LUT_ENTRIES; i++) begin
        lookup_table_first[i]  <= FACTORY_BYTE;
        lookup_table_second[i] <= FACTORY_BYTE;
      end
      for (int i = 0; i < AUX_BYTES; i++) begin
        aux_user_memory[i] <= FACTORY_BYTE;
      end
    end else begin
      if (wr_first_lut) begin
        lookup_table_first[lut_slot] <= i_access.wdata;
      end
      if (wr_second_lut) begin
        lookup_table_second[lut_slot] <= i_access.wdata;
      end
      if (wr_aux) begin
        aux_user_memory[i_access.offset] <= i_access.wdata;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_rdata  <= '0;
      o_rvalid <= 1'b0;
      o_denied <= 1'b0;
    end else begin
      o_rvalid <= i_access.read;
      o_rdata  <= i_access.read ? read_data : o_rdata;
      o_denied <= (i_access.read && !read_ok) || (i_access.write && !write_ok);
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  sequence s_first_auto_load;
    i_conversion_done && !first_manual;
  endsequence
  sequence s_second_auto_load;
    i_conversion_done && !second_manual;
  endsequence
  sequence s_quiet_first;
    !i_conversion_done && !wr_first_hi && !wr_first_lo;
  endsequence

  property p_index_tracks;
    i_conversion_done |=> o_temperature_table_index == $past(index_calc) &&
                          o_temperature_table_index <= INDEX_LAST;
  endproperty
  a_index_tracks: assert property (p_index_tracks) else $error("table index wrong after conversion");

  property p_index_cold;
    (i_conversion_done && i_temperature <= -8'sd40) |=> o_temperature_table_index == '0;
  endproperty
  a_index_cold: assert property (p_index_cold) else $error("cold reading not on first entry");

  property p_first_load;
    s_first_auto_load |=> o_first_output_value == $past(first_aligned);
  endproperty
  a_first_load: assert property (p_first_load) else $error("first output not loaded from table");

  property p_first_hold;
    s_quiet_first ##1 s_quiet_first |=> $stable(o_first_output_value) && o_first_output_value == $past(o_first_output_value, 2);
  endproperty
  a_first_hold: assert property (p_first_hold) else $error("first output changed between conversions");

  property p_first_manual;
    (i_conversion_done && first_manual && !wr_first_hi && !wr_first_lo) |=> $stable(o_first_output_value);
  endproperty
  a_first_manual: assert property (p_first_manual) else $error("first output loaded in manual mode");

  property p_first_align;
    s_first_auto_load |=> ($past(mode[MODE_FIRST_ALIGN]) ? !o_first_output_value[0] : !o_first_output_value[CODE_W-1]);
  endproperty
  a_first_align: assert property (p_first_align) else $error("first output entry misaligned");

  property p_second_load;
    s_second_auto_load |=> o_second_output_value == $past(second_aligned);
  endproperty
  a_second_load: assert property (p_second_load) else $error("second output not loaded from table");

  property p_second_manual;
    (i_conversion_done && second_manual && !wr_second_hi && !wr_second_lo) |=> $stable(o_second_output_value);
  endproperty
  a_second_manual: assert property (p_second_manual) else $error("second output loaded in manual mode");

  property p_second_align;
    s_second_auto_load |=> ($past(mode[MODE_SECOND_ALIGN]) ? !o_second_output_value[0] : !o_second_output_value[CODE_W-1]);
  endproperty
  a_second_align: assert property (p_second_align) else $error("second output entry misaligned");

  property p_table_write_gate;
    (i_access.write && (is_first || is_second) && in_lut && !tbl_wr_ok) |=> o_denied;
  endproperty
  a_table_write_gate: assert property (p_table_write_gate) else $error("table write not refused");

  property p_table_read_gate;
    // A refused write in the same cycle also raises the refusal flag.
    (i_access.read && (is_first || is_second) && in_lut) |=>
      o_rvalid && (o_denied == (!$past(tbl_rd_ok) || $past(i_access.write && !write_ok)));
  endproperty
  a_table_read_gate: assert property (p_table_read_gate) else $error("table read gate wrong");

  property p_reserved_second;
    (i_access.read && is_second && in_rsvd) |=> o_denied && o_rdata == DENIED_BYTE;
  endproperty
  a_reserved_second: assert property (p_reserved_second) else $error("second table reserved read allowed");

  property p_aux_gate;
    (i_access.read && is_aux && !aux_ok) |=> o_denied && o_rdata == DENIED_BYTE;
  endproperty
  a_aux_gate: assert property (p_aux_gate) else $error("auxiliary read not refused");

  property p_aux_roundtrip;
    (i_access.write && is_aux && aux_ok && !i_access.read) ##1
    (i_access.read && is_aux && aux_ok && i_access.offset == $past(i_access.offset) && !i_access.write)
    |=> o_rdata == $past(i_access.wdata, 2);
  endproperty
  a_aux_roundtrip: assert property (p_aux_roundtrip) else $error("auxiliary byte not stored");

endmodule // tld_setpoint_loader

`default_nettype wire

// [verilog/tld_pkg.sv]
// Constants, table map and carrier types for the temperature table set point loader.
// Assumes an upstream serial slave that turns host frames into single byte accesses.
package tld_pkg;

  // Serial slave addresses, as address bytes with the direction bit clear.
  localparam logic [7:0] AUX_SLAVE_ADDR  = 8'hA0;
  localparam logic [7:0] MAIN_SLAVE_ADDR = 8'hA2;

  // Table select values of the main slave's upper memory.
  localparam logic [7:0] TABLE_CONTROL = 8'h02;
  localparam logic [7:0] TABLE_FIRST   = 8'h07;
  localparam logic [7:0] TABLE_SECOND  = 8'h08;

  // Table layout: 36 entries from 80h, then reserved A4h to A7h.
  localparam int         LUT_ENTRIES = 36;
  localparam int         INDEX_W     = 6;
  localparam logic [7:0] LUT_BASE    = 8'h80;
  localparam logic [7:0] LUT_END     = 8'hA3;
  localparam logic [7:0] RSVD_FIRST  = 8'hA4;
  localparam logic [7:0] RSVD_LAST   = 8'hA7;
  localparam logic [INDEX_W-1:0] INDEX_LAST = 6'h23;
  localparam int         AUX_BYTES   = 256;

  // Control table offsets.
  localparam logic [7:0] CTRL_MODE_ADDR   = 8'h80;
  localparam logic [7:0] CTRL_INDEX_ADDR  = 8'h81;
  localparam logic [7:0] FIRST_VALUE_HI   = 8'h84;
  localparam logic [7:0] FIRST_VALUE_LO   = 8'h85;
  localparam logic [7:0] SECOND_VALUE_HI  = 8'h86;
  localparam logic [7:0] SECOND_VALUE_LO  = 8'h87;

  // Bit positions in the mode byte.
  localparam int MODE_FIRST_MANUAL  = 0;
  localparam int MODE_SECOND_MANUAL = 1;
  localparam int MODE_FIRST_ALIGN   = 2;
  localparam int MODE_SECOND_ALIGN  = 3;
  localparam logic [7:0] MODE_MASK  = 8'h0F;

  // Temperature scale: whole degrees, table starts at -40, 4 degree steps.
  localparam int TEMP_W      = 8;
  localparam int TEMP_SUM_W  = 10;
  localparam logic signed [TEMP_SUM_W-1:0] TEMP_OFFSET = 10'sh028;
  localparam int TEMP_STEP_SHIFT = 2;

  localparam int CODE_W = 9;
  localparam logic [7:0] FACTORY_BYTE = 8'h00;
  localparam logic [7:0] DENIED_BYTE  = 8'h00;

  typedef struct packed {
    logic [7:0] slave;
    logic [7:0] table_sel;
    logic [7:0] offset;
    logic [7:0] wdata;
    logic       write;
    logic       read;
  } tld_access_t;

  typedef struct packed {
    logic high_level_password;
    logic low_level_password;
    logic output_tables_write_grant;
    logic output_tables_read_grant;
    logic aux_memory_grant;
    logic aux_memory_user_grant;
  } tld_security_t;

endpackage

// [verif/tld_host_model.sv]
// Host side model: issues decoded single byte accesses together with the password state.
// Assumes callers enter its tasks between falling edges; one 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tld_host_model (
  input  wire logic                   i_clock,
  output var  tld_pkg::tld_access_t   o_access,
  output var  tld_pkg::tld_security_t o_security
);
  import tld_pkg::*;

  initial begin
    o_access   = '0;
    o_security = '0;
  end

  // Each request is set at a falling edge, so exactly one rising edge takes it.
  task automatic put(input tld_security_t sc, input logic [7:0] s, t, o, w, input logic wr, rd);
    @(negedge i_clock);
    o_security = sc;
    o_access   = '{slave: s, table_sel: t, offset: o, wdata: w, write: wr, read: rd};
  endtask

  // A released bus shows the previous fields inverted, so two releases in a row give back the last request's fields.
  task automatic idle();
    @(negedge i_clock);
    o_access       = ~o_access;
    o_access.write = 1'b0;
    o_access.read  = 1'b0;
  endtask
endmodule // tld_host_model

`default_nettype wire

// [verif/tb_tld_setpoint_loader.sv]
// Self-checking bench for the temperature table set point loader.
// Assumes the design package and the host model compile first; one 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb_tld_setpoint_loader;
  import tld_pkg::*;
  localparam tld_security_t HP = 6'h20;
  logic                     clock = 1'b0;
  logic                     rstn;
  tld_access_t              access;
  tld_security_t            security;
  logic signed [TEMP_W-1:0] temperature;
  logic                     conv_done;
  logic [7:0]               rdata;
  logic                     rvalid;
  logic                     denied;
  logic [INDEX_W-1:0]       index;
  logic [CODE_W-1:0]        value [2];
  logic [7:0]               entry [2][LUT_ENTRIES];
  logic [7:0]               aux [AUX_BYTES];
  logic [7:0]               mode;
  logic [7:0]               o;
  logic [INDEX_W-1:0]       idx;
  logic [CODE_W-1:0]        val [2];
  logic [9:0]               acc_q [$];
  logic [23:0]              conv_q [$];
  logic                     conv_d;
  int                       failures = 0;
  int                       samples_checked = 0;
  int                       seed = 97886;
  int unsigned              r;
  logic [7:0] sl [7] = '{8'hA2, 8'hA2, 8'hA0, 8'hA2, 8'hA2, 8'h50, 8'hA2};
  logic [7:0] ts [7] = '{8'h07, 8'h08, 8'h00, 8'h07, 8'h08, 8'h07, 8'h03};
  logic [7:0] cto [6] = '{8'h80, 8'h81, 8'h84, 8'h85, 8'h86, 8'h87};
  logic [7:0] edge_t [12] = '{8'h80, 8'hD7, 8'hD8, 8'hDB, 8'hDC, 8'hDF, 8'h63, 8'h64, 8'h67, 8'h68, 8'h7F, 8'h00};

  always #4 clock = ~clock;

  tld_setpoint_loader dut_u (
    .i_clock                   (clock),
    .i_rstn                    (rstn),
    .i_access                  (access),
    .i_security                (security),
    .i_temperature             (temperature),
    .i_conversion_done         (conv_done),
    .o_rdata                   (rdata),
    .o_rvalid                  (rvalid),
    .o_denied                  (denied),
    .o_temperature_table_index (index),
    .o_first_output_value      (value[0]),
    .o_second_output_value     (value[1])
  );

  tld_host_model host_u (
    .i_clock    (clock),
    .o_access   (access),
    .o_security (security)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic rst();
    @(negedge clock);
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    foreach (aux[i]) aux[i] = FACTORY_BYTE;
    foreach (entry[k, i]) entry[k][i] = FACTORY_BYTE;
    mode = '0;
    idx = '0;
    val[0] = '0;
    val[1] = '0;
    chk({rvalid, denied, index, value[0], value[1]}, '0);
  endtask

  // Notes the expected answer from the reference state, then hands the request to the host.
  task automatic acc(input tld_security_t sc, input logic [7:0] s, t, o, w, input logic wr, rd);
    logic tw, tr, ok, tab, rsv, lp;
    logic [7:0] d;
    int k;
    lp = sc.low_level_password;
    tw = sc.high_level_password | (lp & sc.output_tables_write_grant);
    tr = tw | (lp & sc.output_tables_read_grant);
    k = (t == TABLE_SECOND) ? 1 : 0;
    tab = s == MAIN_SLAVE_ADDR && t inside {TABLE_FIRST, TABLE_SECOND} && o inside {[LUT_BASE:LUT_END]};
    rsv = s == MAIN_SLAVE_ADDR && t == TABLE_FIRST && o inside {[RSVD_FIRST:RSVD_LAST]};
    ok = 1'b0;
    d = DENIED_BYTE;
    if (s == AUX_SLAVE_ADDR) begin
      ok = sc.high_level_password | (lp & (sc.aux_memory_grant | sc.aux_memory_user_grant));
      d = aux[o];
      if (ok && wr) aux[o] = w;
    end else if (tab || rsv) begin
      ok = wr ? tw : tr;
      d = tab ? entry[k][o - LUT_BASE] : 8'h00;
      if (ok && wr && tab) entry[k][o - LUT_BASE] = w;
    end else if (s == MAIN_SLAVE_ADDR && t == TABLE_CONTROL) begin
      ok = o == CTRL_MODE_ADDR || (o == CTRL_INDEX_ADDR && !wr) || o inside {[FIRST_VALUE_HI:SECOND_VALUE_LO]};
      k = (o >= SECOND_VALUE_HI) ? 1 : 0;
      d = o == CTRL_MODE_ADDR ? mode : o == CTRL_INDEX_ADDR ? 8'(idx) : o[0] ? val[k][7:0] : {7'h00, val[k][8]};
      if (ok && wr && o == CTRL_MODE_ADDR) mode = w & MODE_MASK;
      else if (ok && wr && o[0]) val[k][7:0] = w;
      else if (ok && wr) val[k][8] = w[0];
    end
    if (!ok) d = DENIED_BYTE;
    if (rd || !ok) acc_q.push_back({rd, !ok, rd ? d : 8'h00});
    host_u.put(sc, s, t, o, w, wr, rd);
  endtask

  task automatic conv(input logic signed [7:0] tp);
    int t;
    t = (int'(tp) + 40) >>> 2;
    t = t < 0 ? 0 : (t > 35 ? 35 : t);
    idx = t[INDEX_W-1:0];
    for (int k = 0; k < 2; k++)
      if (!mode[MODE_FIRST_MANUAL + k])
        val[k] = mode[MODE_FIRST_ALIGN + k] ? {entry[k][t], 1'b0} : {1'b0, entry[k][t]};
    conv_q.push_back({idx, val[0], val[1]});
    @(negedge clock);
    temperature = tp;
    conv_done = 1'b1;
    @(negedge clock);
    conv_done = 1'b0;
    temperature = TEMP_W'($random(seed));
  endtask

  always @(posedge clock) conv_d <= conv_done & rstn;

  // Results are compared in the cycle they stand, against the oldest note.
  always @(negedge clock) begin
    if (rvalid | denied)
      chk({rvalid, denied, rvalid ? rdata : 8'h00}, acc_q.size() > 0 ? acc_q.pop_front() : 'x);
    if (conv_d)
      chk({index, value[0], value[1]}, conv_q.size() > 0 ? conv_q.pop_front() : 'x);
  end

  initial begin
    rstn = 1'b0;
    temperature = '0;
    conv_done = 1'b0;
    // The second pass doubles as a reset in mid-run with non-default state.
    for (int pass = 0; pass < 2; pass++) begin
      host_u.idle();
      rst();
      foreach (cto[i]) acc('0, 8'hA2, TABLE_CONTROL, cto[i], 8'h00, 1'b0, 1'b1);
      acc(HP, 8'hA0, 8'h00, 8'hFF, 8'h00, 1'b0, 1'b1);
      for (int s = 0; s < 64; s++) begin
        for (int j = 0; j < 7; j++) begin
          r = $random(seed);
          o = j == 2 ? r[15:8] : (j > 2 && j < 5 ? RSVD_FIRST + 8'(r[9:8]) : LUT_BASE + 8'(r % 36));
          for (int d = 0; d < 2; d++) acc(tld_security_t'(s), sl[j], ts[j], o, r[7:0], d == 0, d == 1);
        end
        acc(tld_security_t'(s), 8'hA2, TABLE_CONTROL, CTRL_INDEX_ADDR, r[23:16], 1'b1, 1'b0);
      end
      for (int i = 0; i < LUT_ENTRIES; i++)
        for (int k = 0; k < 2; k++) acc(HP, 8'hA2, k ? 8'h08 : 8'h07, LUT_BASE + 8'(i), 8'($random(seed)), 1'b1, 1'b0);
      for (int m = 0; m < 48; m++) begin
        r = $random(seed);
        acc(tld_security_t'(r[29:24]), 8'hA2, TABLE_CONTROL, CTRL_MODE_ADDR, r[7:0], 1'b1, 1'b0);
        acc(tld_security_t'(r[29:24]), 8'hA2, TABLE_CONTROL, cto[2 + m % 4], r[15:8], 1'b1, 1'b0);
        host_u.idle();
        conv(m < 12 ? edge_t[m] : r[23:16]);
        foreach (cto[i]) acc(HP, 8'hA2, TABLE_CONTROL, cto[i], 8'h00, 1'b0, 1'b1);
      end
      // Without compensation the host programs one set point into every entry of the second table.
      for (int i = 0; i < LUT_ENTRIES; i++) acc(HP, 8'hA2, TABLE_SECOND, LUT_BASE + 8'(i), 8'h3C, 1'b1, 1'b0);
      host_u.idle();
      conv(r[31:24]);
    end
    host_u.idle();
    repeat (3) @(negedge clock);
    chk(acc_q.size() + conv_q.size(), '0);
    wrap_up();
  end

  // About 3,200 cycles are expected; the limit allows roughly four times that.
  initial begin
    #100_000;
    failures++;
    wrap_up();
  end
endmodule // tb_tld_setpoint_loader

`default_nettype wire
